// File: rtl/cml_pkg.sv
// Constants, register map, encodings and shared decode helpers for the
// instruction execution slice. Assumes a single 100 MHz clock domain.
//
// How it works
// - OR of working register and file register goes to destination, zero flag updated
// - Destination bit 0 writes working register, 1 writes the addressed file register
// - Increment adds one to the file register and routes it by destination bit
// - Move-file copies the file register to the chosen destination in one cycle
// - Move-file sets the zero flag from the moved value, even writing back
// - Store-working-register copies work into the file register, flags untouched, one cycle
// - Load-literal puts the 8-bit immediate into work, flags untouched, one cycle
// - Return pops the stack into the program counter, two cycles, only the underflow flag set, on an empty stack
// - Rotate-left moves old carry into bit 0 and old bit 7 into carry
package cml_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DW = 8;
    localparam int FAW = 7;
    localparam int PCW = 13;
    localparam int IW = 12;
    localparam int AW = 8;
    localparam int BUS_W = 32;
    localparam int STK_DEPTH = 8;
    localparam int SPW = 4;
    localparam int SIW = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] REG_INSTR = 8'h00;
    localparam logic [AW-1:0] REG_WORK = 8'h04;
    localparam logic [AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AW-1:0] REG_PC = 8'h0C;
    localparam logic [AW-1:0] REG_STACK = 8'h10;
    localparam logic [AW-1:0] REG_FADDR = 8'h14;
    localparam logic [AW-1:0] REG_FDATA = 8'h18;
    localparam logic [AW-1:0] REG_CYCLES = 8'h1C;

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam int OP_MSB = 11;
    localparam int OP_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int F_MSB = 6;
    localparam int LIT_MSB = 7;
    localparam int STK_DEPTH_LSB = 16;

    // Opcodes
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_OR_WORK_WITH_FILE = 4'h1;
    localparam logic [3:0] OP_INCREMENT_FILE = 4'h2;
    localparam logic [3:0] OP_MOVE_FILE = 4'h3;
    localparam logic [3:0] OP_STORE_WORK_TO_FILE = 4'h4;
    localparam logic [3:0] OP_LOAD_LITERAL_TO_WORK = 4'h5;
    localparam logic [3:0] OP_RETURN = 4'h6;
    localparam logic [3:0] OP_ROTATE_LEFT_THROUGH_CARRY = 4'h7;

    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_Z = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_ILL = 3;
    localparam int ST_UNF = 4;
    localparam int ST_OVF = 5;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [DW-1:0] WORK_RST = 8'h00;
    localparam logic [PCW-1:0] PC_RST = 13'h0000;
    localparam logic [IW-1:0] INSTR_RST = 12'h000;
    localparam logic [FAW-1:0] FADDR_RST = 7'h00;
    localparam logic [BUS_W-1:0] WORD_ZERO = 32'h00000000;
    localparam logic [BUS_W-1:0] CYC_STEP = 32'h00000001;
    localparam logic [PCW-1:0] PC_STEP = 13'h0001;
    localparam logic [DW-1:0] INC_STEP = 8'h01;
    localparam logic [SPW-1:0] SP_STEP = 4'h1;
    localparam logic [SPW-1:0] SP_FULL = 4'h8;
    localparam logic [SPW-1:0] SP_EMPTY = 4'h0;

    // One-hot execution states
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_READ = 5'b00010,
        S_EXEC = 5'b00100,
        S_RET2 = 5'b01000,
        S_BUSRD = 5'b10000
    } cml_state_t;

    // File operand of an instruction word
    function automatic logic [FAW-1:0] file_addr(input logic [IW-1:0] ins);
        file_addr = ins[F_MSB:0];
    endfunction

    // Opcodes whose result may go back into the file register
    function automatic logic dest_op(input logic [3:0] op);
        dest_op = (op == OP_OR_WORK_WITH_FILE) || (op == OP_INCREMENT_FILE) ||
                  (op == OP_MOVE_FILE) || (op == OP_ROTATE_LEFT_THROUGH_CARRY);
    endfunction

endpackage

// File: rtl/cml_fmem.sv
// File register memory, 128 bytes, one write and one read port.
// Read data come out of a register one clock after the address.
`timescale 1ns/100ps
module cml_fmem (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [cml_pkg::FAW-1:0] waddr_i,
    input wire logic [cml_pkg::DW-1:0] wdata_i,
    input wire logic [cml_pkg::FAW-1:0] raddr_i,
    output logic [cml_pkg::DW-1:0] rdata_o
);
    import cml_pkg::*;

    logic [DW-1:0] mem [2**FAW];
    logic [DW-1:0] next_rdata;

    // Read before write: a same-cycle write is seen one access later
    always_comb begin
        next_rdata = mem[raddr_i];
    end

    // Array holds no reset, so it maps onto plain RAM
    always_ff @(posedge sys_clk_i) begin
        if (ce_i && we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= WORK_RST;
        end else if (ce_i) begin
            rdata_o <= next_rdata;
        end
    end

endmodule

// File: rtl/cml_core.sv
// Execution slice of an 8-bit accumulator core with an APB register port.
// Assumes an APB master on sys_clk_i; the file memory sits in cml_fmem.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module cml_core (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [cml_pkg::AW-1:0] paddr_i,
    input wire logic [cml_pkg::BUS_W-1:0] pwdata_i,
    output logic [cml_pkg::BUS_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import cml_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cml_state_t state, next_state;
    logic [IW-1:0] instr, next_instr;
    logic [DW-1:0] work, next_work;
    logic carry, next_carry;
    logic zero, next_zero;
    logic ill, next_ill;
    logic unf, next_unf;
    logic ovf, next_ovf;
    logic [PCW-1:0] pc, next_pc;
    logic [PCW-1:0] stack [STK_DEPTH];
    logic [PCW-1:0] next_stack [STK_DEPTH];
    logic [SPW-1:0] sp, next_sp;
    logic [BUS_W-1:0] cycles, next_cycles;
    logic [FAW-1:0] faddr, next_faddr;
    logic rsp, next_rsp;
    logic [BUS_W-1:0] next_rdata;

    logic mem_we;
    logic [FAW-1:0] mem_waddr;
    logic [DW-1:0] mem_wdata;
    logic [FAW-1:0] mem_raddr;
    logic [DW-1:0] mem_rdata;

    logic [3:0] op;
    logic dest;
    logic [FAW-1:0] fa;
    logic [DW-1:0] lit;
    logic [DW-1:0] res;
    logic [PCW-1:0] top;
    logic idle, access, bus_wr, rd_start, mapped;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign op = instr[OP_MSB:OP_LSB];
    assign dest = instr[DEST_BIT];
    assign fa = file_addr(instr);
    assign lit = instr[LIT_MSB:0];
    assign top = stack[SIW'(sp - SP_STEP)];
    assign idle = (state == S_IDLE);
    assign access = psel_i && penable_i;
    assign bus_wr = access && pwrite_i && idle;
    assign rd_start = access && !pwrite_i && !rsp && idle;
    assign mapped = (paddr_i == REG_INSTR) || (paddr_i == REG_WORK) || (paddr_i == REG_STATUS) ||
                    (paddr_i == REG_PC) || (paddr_i == REG_STACK) || (paddr_i == REG_FADDR) ||
                    (paddr_i == REG_FDATA) || (paddr_i == REG_CYCLES);

    // Writes stall while an instruction runs, reads answer from a register
    assign pready_o = ce_i && access && (pwrite_i ? idle : rsp);
    assign pslverr_o = pready_o && !mapped;

    // Result of the file-sourced operations
    always_comb begin
        case (op)
            OP_OR_WORK_WITH_FILE: res = work | mem_rdata;
            OP_INCREMENT_FILE: res = mem_rdata + INC_STEP;
            OP_ROTATE_LEFT_THROUGH_CARRY: res = {mem_rdata[DW-2:0], carry};
            default: res = mem_rdata;
        endcase
    end

    // ------------------------------------------------------------
    // File memory ports
    // ------------------------------------------------------------
    // Execution writes and bus writes never overlap: bus writes need idle
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = fa;
        mem_wdata = res;
        if (state == S_EXEC && op == OP_STORE_WORK_TO_FILE) begin
            mem_we = 1'b1;
            mem_wdata = work;
        end else if (state == S_EXEC && dest_op(op) && dest) begin
            mem_we = 1'b1;
        end else if (bus_wr && paddr_i == REG_FDATA) begin
            mem_we = 1'b1;
            mem_waddr = faddr;
            mem_wdata = pwdata_i[DW-1:0];
        end
    end

    assign mem_raddr = (state == S_READ) ? fa : faddr;

    cml_fmem u_fmem (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------
    // Core next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_instr = instr;
        next_work = work;
        next_carry = carry;
        next_zero = zero;
        next_ill = ill;
        next_unf = unf;
        next_ovf = ovf;
        next_pc = pc;
        next_stack = stack;
        next_sp = sp;
        next_cycles = cycles;
        next_faddr = faddr;
        case (state)
            S_IDLE: begin
                if (rd_start && paddr_i == REG_FDATA) begin
                    next_state = S_BUSRD;
                end
                if (bus_wr) begin
                    case (paddr_i)
                        REG_INSTR: begin
                            next_instr = pwdata_i[IW-1:0];
                            next_state = S_READ;
                        end
                        REG_WORK: next_work = pwdata_i[DW-1:0];
                        REG_STATUS: begin
                            next_carry = pwdata_i[ST_C];
                            next_zero = pwdata_i[ST_Z];
                            next_ill = pwdata_i[ST_ILL];
                            next_unf = pwdata_i[ST_UNF];
                            next_ovf = pwdata_i[ST_OVF];
                        end
                        REG_PC: next_pc = pwdata_i[PCW-1:0];
                        REG_STACK: begin
                            // A push on a full stack is dropped and flagged
                            if (sp == SP_FULL) begin
                                next_ovf = 1'b1;
                            end else begin
                                next_stack[SIW'(sp)] = pwdata_i[PCW-1:0];
                                next_sp = sp + SP_STEP;
                            end
                        end
                        REG_FADDR: next_faddr = pwdata_i[FAW-1:0];
                        REG_CYCLES: next_cycles = pwdata_i;
                        default: next_state = state;
                    endcase
                end
            end
            S_READ: begin
                next_state = S_EXEC;
            end
            S_EXEC: begin
                // Every instruction here is one word; all but return (which goes on to S_RET2) end in this cycle
                next_cycles = cycles + CYC_STEP;
                next_pc = pc + PC_STEP;
                next_state = S_IDLE;
                case (op)
                    OP_NOP: next_state = S_IDLE;
                    OP_OR_WORK_WITH_FILE, OP_INCREMENT_FILE, OP_MOVE_FILE: begin
                        next_zero = (res == WORK_RST);
                        if (!dest) begin
                            next_work = res;
                        end
                    end
                    OP_ROTATE_LEFT_THROUGH_CARRY: begin
                        next_carry = mem_rdata[DW-1];
                        if (!dest) begin
                            next_work = res;
                        end
                    end
                    OP_STORE_WORK_TO_FILE: next_state = S_IDLE;
                    OP_LOAD_LITERAL_TO_WORK: next_work = lit;
                    OP_RETURN: begin
                        // Empty stack still loads the wrapped slot, but is flagged
                        next_pc = top;
                        next_state = S_RET2;
                        if (sp == SP_EMPTY) begin
                            next_unf = 1'b1;
                        end else begin
                            next_sp = sp - SP_STEP;
                        end
                    end
                    default: next_ill = 1'b1;
                endcase
            end
            S_RET2: begin
                next_cycles = cycles + CYC_STEP;
                next_state = S_IDLE;
            end
            S_BUSRD: begin
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    // Core registers, frozen while ce_i is low
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= S_IDLE;
            instr <= INSTR_RST;
            work <= WORK_RST;
            carry <= 1'b0;
            zero <= 1'b0;
            ill <= 1'b0;
            unf <= 1'b0;
            ovf <= 1'b0;
            pc <= PC_RST;
            for (int i = 0; i < STK_DEPTH; i++) begin
                stack[i] <= PC_RST;
            end
            sp <= SP_EMPTY;
            cycles <= WORD_ZERO;
            faddr <= FADDR_RST;
        end else if (ce_i) begin
            state <= next_state;
            instr <= next_instr;
            work <= next_work;
            carry <= next_carry;
            zero <= next_zero;
            ill <= next_ill;
            unf <= next_unf;
            ovf <= next_ovf;
            pc <= next_pc;
            stack <= next_stack;
            sp <= next_sp;
            cycles <= next_cycles;
            faddr <= next_faddr;
        end
    end

    // ------------------------------------------------------------
    // Bus read response
    // ------------------------------------------------------------
    // Read data registered one cycle before pready, so prdata is a flop
    always_comb begin
        next_rsp = rsp;
        next_rdata = prdata_o;
        if (rsp && access) begin
            next_rsp = 1'b0;
        end else if (state == S_BUSRD) begin
            next_rsp = 1'b1;
            next_rdata = {{(BUS_W-DW){1'b0}}, mem_rdata};
        end else if (rd_start && paddr_i != REG_FDATA) begin
            next_rsp = 1'b1;
            case (paddr_i)
                REG_INSTR: next_rdata = {{(BUS_W-IW){1'b0}}, instr};
                REG_WORK: next_rdata = {{(BUS_W-DW){1'b0}}, work};
                REG_STATUS: next_rdata = {{(BUS_W-ST_OVF-1){1'b0}}, ovf, unf, ill, !idle, zero, carry};
                REG_PC: next_rdata = {{(BUS_W-PCW){1'b0}}, pc};
                REG_STACK: next_rdata = {{(BUS_W-STK_DEPTH_LSB-SPW){1'b0}}, sp,
                                         {(STK_DEPTH_LSB-PCW){1'b0}}, top};
                REG_FADDR: next_rdata = {{(BUS_W-FAW){1'b0}}, faddr};
                REG_CYCLES: next_rdata = cycles;
                default: next_rdata = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp <= 1'b0;
            prdata_o <= WORD_ZERO;
        end else if (ce_i) begin
            rsp <= next_rsp;
            prdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence exec_op(logic [3:0] code);
        ce_i && state == S_EXEC && op == code;
    endsequence

    a_or_result: assert property (exec_op(OP_OR_WORK_WITH_FILE) and !dest |=>
        work == ($past(work) | $past(mem_rdata)) && zero == (work == WORK_RST))
        else $error("or result or zero flag wrong");
    a_dest_file: assert property (ce_i && state == S_EXEC && dest_op(op) && dest |->
        mem_we && mem_waddr == fa ##1 work == $past(work, 2))
        else $error("file destination not written");
    a_inc_value: assert property (exec_op(OP_INCREMENT_FILE) and !dest |=>
        work == $past(mem_rdata) + INC_STEP)
        else $error("increment result wrong");
    a_move_single: assert property (ce_i && state == S_READ && op == OP_MOVE_FILE |=>
        state == S_EXEC ##1 (state == S_IDLE || !$past(ce_i)))
        else $error("move-file not single cycle");
    a_move_zero: assert property (exec_op(OP_MOVE_FILE) |=>
        zero == ($past(mem_rdata) == WORK_RST))
        else $error("move-file zero flag wrong");
    a_store_flags: assert property (exec_op(OP_STORE_WORK_TO_FILE) |->
        mem_we && mem_wdata == work ##1 $stable(carry) && $stable(zero) && state == S_IDLE)
        else $error("store changed flags or missed write");
    a_literal_load: assert property (exec_op(OP_LOAD_LITERAL_TO_WORK) |=>
        work == $past(lit) && $stable(carry) && $stable(zero))
        else $error("literal load wrong");
    a_return_pc: assert property (exec_op(OP_RETURN) |=>
        pc == $past(top) && state == S_RET2 && $stable(zero) && $stable(carry))
        else $error("return did not load stack top");
    a_rotate_carry: assert property (exec_op(OP_ROTATE_LEFT_THROUGH_CARRY) and !dest |=>
        carry == $past(mem_rdata[DW-1]) && work == {$past(mem_rdata[DW-2:0]), $past(carry)})
        else $error("rotate through carry wrong");
    a_nop_pc: assert property (exec_op(OP_NOP) |-> !mem_we ##1
        pc == $past(pc) + PC_STEP && $stable(work) && $stable(zero) && $stable(carry))
        else $error("nop changed state or pc");
    a_field_decode: assert property (ce_i && state == S_READ && dest_op(op) |=> mem_rdata == u_fmem.mem[fa])
        else $error("file field misdecoded");

endmodule

// File: testbench/tb.sv
// Self-checking bench for the execution slice, driven over APB.
// Assumes cml_core with its file memory inside; one 100 MHz clock.
`timescale 1ns/100ps
module tb;
    import cml_pkg::*;
    logic sys_clk_i;
    logic nrst_i;
    logic ce_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [AW-1:0] paddr_i;
    logic [BUS_W-1:0] pwdata_i;
    logic [BUS_W-1:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic last_err;
    int err_total;
    int checks_done;
    int cyc = 0;

    cml_core DUT (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o)
    );

    // ------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Whole run is about a hundred transfers, so 20000 cycles is ample
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // ------------------------------------------------------------
    // APB master: request held until pready is sampled at an edge
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        // Read just after the edge, before updates land: the sampled values
        do begin
            @(posedge sys_clk_i);
            n = n + 1;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
        end
        q = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    // Read a register and compare it whole
    task automatic chkr(input string nm, input logic [AW-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h00000000, q);
        chk(nm, exp, q);
    endtask

    task automatic setf(input logic [6:0] f, input logic [7:0] v);
        wr(REG_FADDR, {25'h0000000, f});
        wr(REG_FDATA, {24'h000000, v});
    endtask

    task automatic chkf(input string nm, input logic [6:0] f, input logic [7:0] v);
        wr(REG_FADDR, {25'h0000000, f});
        chkr(nm, REG_FDATA, {24'h000000, v});
    endtask

    // Instruction word: opcode, destination bit, file address
    task automatic ins(input logic [3:0] op, input logic d, input logic [6:0] f);
        wr(REG_INSTR, {20'h00000, op, d, f});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_or();
        wr(REG_STATUS, 32'h2);
        wr(REG_WORK, 32'h0C);
        setf(7'h05, 8'h30);
        ins(OP_OR_WORK_WITH_FILE, 1'b1, 7'h05);
        chkf("or file", 7'h05, 8'h3C);
        chkr("or work kept", REG_WORK, 32'h0C);
        chkr("or zero clear", REG_STATUS, 32'h0);
        wr(REG_WORK, 32'h0);
        setf(7'h7F, 8'h00);
        ins(OP_OR_WORK_WITH_FILE, 1'b0, 7'h7F);
        chkr("or zero set", REG_STATUS, 32'h2);
    endtask

    task automatic s_inc();
        wr(REG_STATUS, 32'h0);
        setf(7'h7F, 8'hFF);
        ins(OP_INCREMENT_FILE, 1'b1, 7'h7F);
        chkf("inc wrap", 7'h7F, 8'h00);
        chkr("inc zero", REG_STATUS, 32'h2);
        setf(7'h03, 8'h41);
        ins(OP_INCREMENT_FILE, 1'b0, 7'h03);
        chkr("inc work", REG_WORK, 32'h42);
        chkf("inc file kept", 7'h03, 8'h41);
    endtask

    task automatic s_move();
        wr(REG_STATUS, 32'h0);
        wr(REG_WORK, 32'h55);
        wr(REG_CYCLES, 32'h0);
        setf(7'h0A, 8'h00);
        ins(OP_MOVE_FILE, 1'b1, 7'h0A);
        chkr("move test zero", REG_STATUS, 32'h2);
        chkr("move work kept", REG_WORK, 32'h55);
        chkr("move cycles", REG_CYCLES, 32'h1);
        chkf("move file kept", 7'h0A, 8'h00);
        setf(7'h0A, 8'h80);
        ins(OP_MOVE_FILE, 1'b0, 7'h0A);
        chkr("move work", REG_WORK, 32'h80);
        chkr("move zero clear", REG_STATUS, 32'h0);
    endtask

    task automatic s_store();
        wr(REG_STATUS, 32'h3);
        wr(REG_WORK, 32'h4F);
        wr(REG_CYCLES, 32'h0);
        setf(7'h14, 8'hFF);
        ins(OP_STORE_WORK_TO_FILE, 1'b0, 7'h14);
        chkf("store file", 7'h14, 8'h4F);
        chkr("store flags", REG_STATUS, 32'h3);
        chkr("store cycles", REG_CYCLES, 32'h1);
    endtask

    task automatic s_lit();
        wr(REG_STATUS, 32'h3);
        wr(REG_CYCLES, 32'h0);
        wr(REG_PC, 32'h10);
        ins(OP_LOAD_LITERAL_TO_WORK, 1'b1, 7'h25);
        chkr("literal work", REG_WORK, 32'hA5);
        chkr("literal flags", REG_STATUS, 32'h3);
        chkr("literal cycles", REG_CYCLES, 32'h1);
        chkr("literal pc", REG_PC, 32'h11);
    endtask

    task automatic s_ret();
        logic [31:0] q;
        wr(REG_STATUS, 32'h1);
        wr(REG_STACK, 32'h0ABC);
        wr(REG_CYCLES, 32'h0);
        wr(REG_PC, 32'h40);
        ins(OP_RETURN, 1'b0, 7'h00);
        chkr("return pc", REG_PC, 32'h0ABC);
        chkr("return cycles", REG_CYCLES, 32'h2);
        chkr("return flags", REG_STATUS, 32'h1);
        apb(1'b0, REG_STACK, 32'h0, q);
        chk("return depth", 32'h0, {28'h0000000, q[19:16]});
        ins(OP_RETURN, 1'b0, 7'h00);
        chkr("return underflow", REG_STATUS, 32'h11);
        repeat (9) wr(REG_STACK, 32'h1);
        chkr("push overflow", REG_STATUS, 32'h31);
    endtask

    task automatic s_rot();
        wr(REG_STATUS, 32'h1);
        wr(REG_WORK, 32'h0);
        setf(7'h01, 8'hE6);
        ins(OP_ROTATE_LEFT_THROUGH_CARRY, 1'b0, 7'h01);
        chkr("rotate work", REG_WORK, 32'hCD);
        chkr("rotate carry set", REG_STATUS, 32'h1);
        chkf("rotate file kept", 7'h01, 8'hE6);
        wr(REG_STATUS, 32'h2);
        setf(7'h01, 8'h66);
        ins(OP_ROTATE_LEFT_THROUGH_CARRY, 1'b1, 7'h01);
        chkf("rotate file", 7'h01, 8'hCC);
        chkr("rotate carry clear", REG_STATUS, 32'h2);
    endtask

    task automatic s_nop();
        wr(REG_STATUS, 32'h3);
        wr(REG_WORK, 32'h77);
        wr(REG_PC, 32'h5);
        wr(REG_CYCLES, 32'h0);
        ins(OP_NOP, 1'b0, 7'h00);
        // Freeze mid-instruction: nothing may advance twice
        ce_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        ce_i <= 1'b1;
        chkr("nop pc", REG_PC, 32'h6);
        chkr("nop work", REG_WORK, 32'h77);
        chkr("nop flags", REG_STATUS, 32'h3);
        chkr("nop cycles", REG_CYCLES, 32'h1);
        ins(4'h8, 1'b0, 7'h00);
        chkr("illegal flag", REG_STATUS, 32'hB);
        chkr("illegal pc", REG_PC, 32'h7);
    endtask

    // Unmapped place reads zero and flags a slave error
    task automatic s_unmap();
        chkr("unmapped data", 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h00000000, last_err});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        checks_done = 0;
        nrst_i = 1'b0;
        ce_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h00000000;
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        s_or();
        s_inc();
        s_move();
        s_store();
        s_lit();
        s_ret();
        s_rot();
        s_nop();
        s_unmap();
        stop_test();
    end
endmodule
